/* shared/plcr_pkg.sv */
package plcr_pkg;
  // register indices as seen by the management side (byte address = index * 4)
  localparam logic [4:0]  IDX_GOOD_CRC   = 5'h12;  // on extended page one
  localparam logic [4:0]  IDX_BEHAVIOR   = 5'h1E;  // main page
  localparam logic [4:0]  IDX_PAGE_SEL   = 5'h1F;  // always reachable
  localparam logic [4:0]  IDX_PAGED_LO   = 5'h10;  // first paged index
  // block-local registers beyond the management map
  localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h80;
  localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h84;
  localparam logic [7:0]  ADDR_SOFT_RST  = 8'h88;
  // page codes
  localparam logic [15:0] PAGE_MAIN      = 16'h0000;
  localparam logic [15:0] PAGE_EXT1      = 16'h0001;
  localparam logic [15:0] PAGE_EXT2      = 16'h0002;
  localparam logic [15:0] PAGE_EXT3      = 16'h0003;
  localparam logic [15:0] PAGE_EXT4      = 16'h0004;
  localparam logic [15:0] PAGE_GPIO      = 16'h0010;
  // behaviour register fields
  localparam int          BIT_PULSE_EN   = 12;
  localparam int          BIT_RATE_LO    = 10;
  localparam int          BIT_SEL_LO     = 5;
  localparam logic [15:0] BEH_WMASK      = 16'hDDE3;  // writable bits
  localparam logic [15:0] BEH_RESET      = 16'h0400;  // rate field = 01
  // counter register fields
  localparam int          BIT_SINCE_READ = 15;
  localparam logic [13:0] CRC_MODULUS_M1 = 14'h270F;  // 9,999
  // timing
  localparam int          CLK_HZ         = 125_000_000;
  localparam int          PULSE_HZ       = 5_000;
  localparam int          PULSE_CYC      = CLK_HZ / PULSE_HZ;
  localparam int          STRETCH_MS_MAX = 400;        // rate 00
  localparam int          BLINK_HALF_MS  = 200;        // 2.5 Hz half period
  localparam logic [1:0]  AXI_OKAY       = 2'b00;
  localparam logic [1:0]  AXI_SLVERR     = 2'b10;
  // bus slave states
  typedef enum logic [2:0] {
    PLCR_IDLE = 3'b001,
    PLCR_WRSP = 3'b010,
    PLCR_RRSP = 3'b100
  } plcr_bus_state_t;
endpackage

/* design/plcr_indicator.sv */
`timescale 1ns/100ps
// one indicator output: blink or pulse-stretch, then optional pulsing
module plcr_indicator #(
  parameter int STRETCH_W = 26
) (
  // clock and reset
  input  wire logic                 mclk,
  input  wire logic                 resetn,
  input  wire logic                 clk_en,
  // shared timing
  input  wire logic                 blink_phase,
  input  wire logic [STRETCH_W-1:0] stretch_cyc,
  input  wire logic                 pulse_on,
  input  wire logic                 pulsing_en,
  // per indicator
  input  wire logic                 stretch_sel,
  input  wire logic                 steady_in,
  input  wire logic                 event_in,
  output logic                      ind_out
);
  logic [STRETCH_W-1:0] hold_q;  // remaining stretch cycles
  logic                 shown;

  // each event reloads the full stretch time, so bursts keep it lit
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      hold_q <= '0;
    end else if (clk_en) begin
      if (event_in) begin
        hold_q <= stretch_cyc;
      end else if (hold_q != '0) begin
        hold_q <= hold_q - 1'b1;
      end
    end
  end

  // stretch shows held activity, blink gates activity with the blink phase
  always_comb begin
    if (stretch_sel) begin
      shown = steady_in | event_in | (hold_q != '0);
    end else begin
      shown = steady_in | (event_in & blink_phase);
    end
  end

  // registered output; pulsing chops an active output at the pulse rate
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ind_out <= 1'b0;
    end else if (clk_en) begin
      ind_out <= shown & (~pulsing_en | pulse_on);
    end
  end
endmodule

/* design/plcr_regs.sv */
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
module plcr_regs
  import plcr_pkg::*;
#(
  parameter int          CLK_FREQ_HZ = CLK_HZ,
  parameter int          DUTY_W      = 8,
  parameter logic [1:0]  PORT_INDEX  = 2'h0
) (
  // clock, enable and reset
  input  wire logic        mclk,
  input  wire logic        resetn,
  input  wire logic        clk_en,
  // axi4-lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // axi4-lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // axi4-lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // rate field from port zero's copy
  input  wire logic [1:0]  port_zero_rate,
  output logic [1:0]       rate_field,
  // link state and events
  input  wire logic        good_crc_pkt,
  input  wire logic        link_up,
  input  wire logic        full_duplex,
  input  wire logic [3:0]  ind_activity,
  input  wire logic        collision,
  input  wire logic [1:0]  ind_steady_23,
  input  wire logic [DUTY_W-1:0] pulse_duty,
  // indicator outputs and interrupt
  output logic [3:0]       indicator,
  output logic             irq
);
  localparam int STRETCH_W = $clog2(CLK_FREQ_HZ / 1000 * STRETCH_MS_MAX + 1);
  localparam int PULSE_C   = CLK_FREQ_HZ / PULSE_HZ;
  localparam int PULSE_W   = $clog2(PULSE_C);
  localparam int BLINK_C   = CLK_FREQ_HZ / 1000 * BLINK_HALF_MS;

  // refuse settings that the counters cannot serve; the duty field must fit
  // the pulse counter, or the duty shift goes negative and pulsing blanks
  // every indicator
  if (CLK_FREQ_HZ < 2 * PULSE_HZ || DUTY_W > PULSE_W) begin : g_bad_cfg
    $error("plcr_regs: clock too slow for indicator timing");
  end

  plcr_bus_state_t  st_q;          // bus slave state
  logic [7:0]       awaddr_q;      // latched write address
  logic             aw_have_q;     // write address held
  logic [31:0]      wdata_q;       // latched write data
  logic [3:0]       wstrb_q;
  logic             w_have_q;      // write data held
  logic [15:0]      page_q;        // page select
  logic [15:0]      beh_q;         // indicator behaviour
  logic [13:0]      crc_cnt_q;     // good packet count
  logic             since_q;       // packet since last read
  logic [1:0]       irq_stat_q;    // sticky events: 0 packet, 1 wrap
  logic [1:0]       irq_mask_q;
  logic             soft_rst_q;    // one-cycle soft reset pulse
  logic             do_write;
  logic             do_read;
  logic             rd_crc;        // read hits the counter
  logic             rd_stat;       // read hits irq status
  logic             crc_wrap;
  logic [15:0]      wr16;
  logic [15:0]      rd_val;
  logic             rd_ok;

  // decode a byte address into a management target on the current page
  // 0 none, 1 page sel, 2 behaviour, 3 good-crc, 4 other main/standard
  function automatic logic [2:0] decode(input logic [7:0] a, input logic [15:0] pg);
    logic [4:0] idx;
    idx = a[6:2];
    decode = 3'h0;
    if (a[7] || a[1:0] != 2'b00) begin
      decode = 3'h0;
    end else if (idx == IDX_PAGE_SEL) begin
      decode = 3'h1;
    end else if (pg == PAGE_GPIO) begin
      decode = 3'h0;
    end else if (idx < IDX_PAGED_LO) begin
      decode = 3'h4;
    end else if (pg == PAGE_MAIN) begin
      decode = (idx == IDX_BEHAVIOR) ? 3'h2 : 3'h4;
    end else if (pg == PAGE_EXT1) begin
      decode = (idx == IDX_GOOD_CRC) ? 3'h3 : 3'h0;
    end else begin
      decode = 3'h0;
    end
  endfunction

  assign s_axi_awready = (st_q == PLCR_IDLE) && !aw_have_q;
  assign s_axi_wready  = (st_q == PLCR_IDLE) && !w_have_q;
  assign s_axi_arready = (st_q == PLCR_IDLE) && !aw_have_q && !w_have_q;
  assign do_write      = clk_en && (st_q == PLCR_IDLE) && aw_have_q && w_have_q;
  assign do_read       = clk_en && s_axi_arready && s_axi_arvalid;
  assign wr16          = wdata_q[15:0];
  assign rd_crc        = do_read && decode(s_axi_araddr, page_q) == 3'h3;
  assign rd_stat       = do_read && s_axi_araddr == ADDR_IRQ_STAT;
  assign crc_wrap      = good_crc_pkt && crc_cnt_q == CRC_MODULUS_M1;
  assign rate_field    = beh_q[BIT_RATE_LO +: 2];

  // address and data are captured independently, in either order
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      awaddr_q  <= 8'h00;
      aw_have_q <= 1'b0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
      w_have_q  <= 1'b0;
    end else if (clk_en) begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q  <= s_axi_awaddr;
        aw_have_q <= 1'b1;
      end else if (do_write) begin
        aw_have_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
        w_have_q <= 1'b1;
      end else if (do_write) begin
        w_have_q <= 1'b0;
      end
    end
  end

  // response state machine; a held write beats a read arriving in the same cycle, writes wait while one is open
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q         <= PLCR_IDLE;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= AXI_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= AXI_OKAY;
      s_axi_rdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      case (st_q)
        PLCR_IDLE: begin
          if (do_write) begin
            st_q         <= PLCR_WRSP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (decode(awaddr_q, page_q) != 3'h0 || awaddr_q >= ADDR_IRQ_STAT
                             && awaddr_q <= ADDR_SOFT_RST) ? AXI_OKAY : AXI_SLVERR;
          end else if (do_read) begin
            st_q         <= PLCR_RRSP;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= rd_ok ? AXI_OKAY : AXI_SLVERR;
            s_axi_rdata  <= {16'h0000, rd_val};
          end
        end
        PLCR_WRSP: begin
          if (s_axi_bready) begin
            st_q         <= PLCR_IDLE;
            s_axi_bvalid <= 1'b0;
          end
        end
        PLCR_RRSP: begin
          if (s_axi_rready) begin
            st_q         <= PLCR_IDLE;
            s_axi_rvalid <= 1'b0;
          end
        end
        default: begin
          st_q <= PLCR_IDLE;
        end
      endcase
    end
  end

  // read mux; unused standard registers read as zero
  always_comb begin
    rd_val = 16'h0000;
    rd_ok  = 1'b1;
    if (s_axi_araddr == ADDR_IRQ_STAT) begin
      rd_val = {14'h0000, irq_stat_q};
    end else if (s_axi_araddr == ADDR_IRQ_MASK) begin
      rd_val = {14'h0000, irq_mask_q};
    end else if (s_axi_araddr == ADDR_SOFT_RST) begin
      rd_val = 16'h0000;
    end else begin
      case (decode(s_axi_araddr, page_q))
        3'h1:    rd_val = page_q;
        3'h2:    rd_val = beh_q;
        3'h3:    rd_val = {since_q, 1'b0, crc_cnt_q};
        3'h4:    rd_val = 16'h0000;
        default: rd_ok  = 1'b0;
      endcase
    end
  end

  // page select; soft reset returns to the main space
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      page_q <= PAGE_MAIN;
    end else if (clk_en) begin
      if (soft_rst_q) begin
        page_q <= PAGE_MAIN;
      end else if (do_write && decode(awaddr_q, page_q) == 3'h1 && wstrb_q[1:0] == 2'b11) begin
        page_q <= wr16;
      end
    end
  end

  // behaviour bits are sticky: only the hardware reset restores them
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      beh_q <= BEH_RESET;
    end else if (clk_en && do_write && decode(awaddr_q, page_q) == 3'h2) begin
      beh_q <= (beh_q & ~BEH_WMASK) | (wr16 & BEH_WMASK);
    end
  end

  // counter: a packet arriving on the clearing read is counted as the new first
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      crc_cnt_q <= 14'h0000;
      since_q   <= 1'b0;
    end else if (clk_en) begin
      if (good_crc_pkt) begin
        since_q <= 1'b1;
      end else if (rd_crc) begin
        since_q <= 1'b0;
      end
      if (rd_crc) begin
        crc_cnt_q <= good_crc_pkt ? 14'h0001 : 14'h0000;
      end else if (good_crc_pkt) begin
        crc_cnt_q <= crc_wrap ? 14'h0000 : crc_cnt_q + 14'h0001;
      end
    end
  end

  // interrupt status, mask and soft reset; a new event beats the read clear
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      irq_stat_q <= 2'b00;
      irq_mask_q <= 2'b00;
      soft_rst_q <= 1'b0;
    end else if (clk_en) begin
      irq_stat_q <= (rd_stat ? 2'b00 : irq_stat_q) | {crc_wrap, good_crc_pkt};
      soft_rst_q <= do_write && awaddr_q == ADDR_SOFT_RST && wdata_q[0];
      if (do_write && awaddr_q == ADDR_IRQ_MASK) begin
        irq_mask_q <= wdata_q[1:0];
      end
    end
  end

  assign irq = |(irq_stat_q & irq_mask_q);

  // shared timing: port zero's own field, otherwise the field fed from port zero
  logic [1:0]           rate_used;
  logic [STRETCH_W-1:0] stretch_cyc;
  logic [31:0]          blink_lim;
  logic [31:0]          blink_q;
  logic                 blink_phase_q;
  logic [PULSE_W-1:0]   pulse_q;
  assign rate_used   = (PORT_INDEX == 2'h0) ? rate_field : port_zero_rate;
  assign stretch_cyc = STRETCH_W'((CLK_FREQ_HZ / 1000 * STRETCH_MS_MAX) >> rate_used);
  assign blink_lim   = 32'(BLINK_C) >> rate_used;

  // blink phase toggles every half period; pulse counter runs at 5 kHz
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      blink_q       <= 32'h0000_0000;
      blink_phase_q <= 1'b0;
      pulse_q       <= '0;
    end else if (clk_en) begin
      if (blink_q + 32'h0000_0001 >= blink_lim) begin
        blink_q       <= 32'h0000_0000;
        blink_phase_q <= ~blink_phase_q;
      end else begin
        blink_q <= blink_q + 32'h0000_0001;
      end
      pulse_q <= (pulse_q == PULSE_W'(PULSE_C - 1)) ? '0 : pulse_q + 1'b1;
    end
  end

  // combine: indicator zero link/activity, indicator one duplex/collision
  logic [3:0] steady;
  logic [3:0] events;
  always_comb begin
    steady = {ind_steady_23, full_duplex, link_up};
    events = ind_activity;
    events[0] = ind_activity[0] & link_up & ~beh_q[0];
    events[1] = (ind_activity[1] | collision) & ~beh_q[1];
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_ind
      plcr_indicator #(
        .STRETCH_W (STRETCH_W)
      ) u_ind (
        .mclk        (mclk),
        .resetn      (resetn),
        .clk_en      (clk_en),
        .blink_phase (blink_phase_q),
        .stretch_cyc (stretch_cyc),
        .pulse_on    (pulse_q < PULSE_W'(pulse_duty) << (PULSE_W - DUTY_W)),
        .pulsing_en  (beh_q[BIT_PULSE_EN]),
        .stretch_sel (beh_q[BIT_SEL_LO + gi]),
        .steady_in   (steady[gi]),
        .event_in    (events[gi]),
        .ind_out     (indicator[gi])
      );
    end
  endgenerate
endmodule

/* testbench/plcr_regs_sva.sv */
`timescale 1ns/100ps
// bus-side timing watch on the register bank slave
module plcr_regs_sva
  import plcr_pkg::*;
(
  // clock and reset
  input wire logic        mclk,
  input wire logic        resetn,
  // write channels
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  // read channels
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // both write halves taken at one edge
  sequence s_wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  // read address taken
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_wr_answer_due: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  a_rd_answer_due: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer missing");
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  a_rdata_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  a_refused_reads_zero: assert property (s_axi_rvalid && s_axi_rresp == AXI_SLVERR
    |-> s_axi_rdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_one_answer: assert property (!(s_axi_bvalid && s_axi_rvalid))
    else $error("two answers at once");
  a_busy_no_read: assert property (s_axi_bvalid || s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
endmodule

bind plcr_regs plcr_regs_sva u_sva (
  .mclk(mclk), .resetn(resetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready)
);

/* testbench/plcr_mgmt_host.sv */
`timescale 1ns/100ps
// management controller: one axi4-lite transfer at a time
module plcr_mgmt_host (
  // clock
  input  wire logic        mclk,
  // write channels
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic        bvalid,
  output logic             bready,
  // read channels
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  int tmo = 0;  // waits that ran out
  initial begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    {awaddr, araddr, wdata, wstrb} = '0;
  end
  // released payload shows the inverse, so a stale copy never matches
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr  <= a;
    awvalid <= 1'b1;
    wdata   <= d;
    wstrb   <= 4'hF;
    wvalid  <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
      // ready raised late so the slave must hold its answer
      bready <= bvalid && !bready;
    end while (!(bvalid && bready) && n < 200);
    if (!(bvalid && bready)) tmo++;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    n = 0;
    araddr  <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr  <= ~a;
      end
      rready <= rvalid && !rready;
    end while (!(rvalid && rready) && n < 200);
    if (!(rvalid && rready)) tmo++;
    d = rdata;
    r = rresp;
  endtask
endmodule

/* testbench/tb_top.sv */
`timescale 1ns/100ps
// register bank bench: bus, paging, counter, interrupt, indicators
module tb_top;
  import plcr_pkg::*;
  logic        mclk = 1'b0, resetn = 1'b0;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb, indicator;
  logic [1:0]  bresp, rresp, rate_field;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, irq;
  logic        good_crc_pkt = 1'b0, link_up = 1'b0;
  logic        full_duplex = 1'b0, collision = 1'b0;
  logic [3:0]  pulse_duty = 4'h1;
  logic [1:0]  ind_steady_23 = 2'b00;
  logic [3:0]  ind_activity = 4'h0;
  logic [15:0] d;
  logic [15:0] pg[5] = '{PAGE_EXT1, PAGE_EXT2, PAGE_EXT3, PAGE_EXT4, PAGE_GPIO};
  int          miscompares = 0, cmp_count = 0, t, n;
  initial begin
    forever #4 mclk = ~mclk;
  end
  // short clock figure keeps indicator timing in reach
  // duty field narrowed to fit the shortened 5 kHz pulse counter
  plcr_regs #(.CLK_FREQ_HZ(100000), .DUTY_W(4)) dut_u (
    .mclk(mclk), .resetn(resetn), .clk_en(1'b1),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .port_zero_rate(2'b00), .rate_field(rate_field), .good_crc_pkt(good_crc_pkt),
    .link_up(link_up), .full_duplex(full_duplex), .ind_activity(ind_activity),
    .collision(collision), .ind_steady_23(ind_steady_23), .pulse_duty(pulse_duty),
    .indicator(indicator), .irq(irq)
  );
  plcr_mgmt_host hm_u (
    .mclk(mclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready)
  );
  // counter word after n good packets since the last read
  function automatic logic [31:0] exp_crc(input int n);
    return {16'h0000, n > 0, 1'b0, 14'(n % 10000)};
  endfunction
  // only writable behaviour bits read back
  function automatic logic [31:0] exp_beh(input logic [15:0] v);
    return {16'h0000, v & BEH_WMASK};
  endfunction
  task automatic report_and_stop();
    miscompares += hm_u.tmo;
    $display("compares %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk_d(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t value %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_r(input logic [1:0] g, input logic [1:0] e);
    cmp_count++;
    if (g !== e) begin
      miscompares++;
      $display("[FAIL] %0t response %b expected %b", $time, g, e);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] v;
    logic [1:0]  r;
    hm_u.rd(a, v, r);
    chk_d(v, e);
    chk_r(r, er);
    if (hm_u.tmo != 0) report_and_stop();
  endtask
  task automatic pkts(input int k);
    repeat (k) begin
      good_crc_pkt <= 1'b1;
      @(posedge mclk);
      good_crc_pkt <= 1'b0;
      @(posedge mclk);
    end
  endtask
  // edges seen on indicator two over ten pulse periods
  task automatic toggles(output int c);
    logic p;
    c = 0;
    p = indicator[2];
    repeat (200) begin
      @(posedge mclk);
      if (indicator[2] !== p) c++;
      p = indicator[2];
    end
  endtask
  initial begin
    void'($urandom(32'h09E45B69));
    // duty kept below the full period so pulsing really chops the output
    pulse_duty <= 4'(1 + $urandom() % 9);
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    rd_chk(8'h7C, 32'h0, AXI_OKAY);
    rd_chk(8'h78, {16'h0, BEH_RESET}, AXI_OKAY);
    d = 16'($urandom());
    hm_u.wr(8'h78, {16'h0, d});
    rd_chk(8'h78, exp_beh(d), AXI_OKAY);
    chk_d({30'h0, rate_field}, {30'h0, d[11:10]});
    // soft reset returns the page but keeps behaviour bits
    hm_u.wr(8'h7C, 32'h1);
    hm_u.wr(8'h88, 32'h1);
    rd_chk(8'h7C, 32'h0, AXI_OKAY);
    rd_chk(8'h78, exp_beh(d), AXI_OKAY);
    foreach (pg[i]) begin
      hm_u.wr(8'h7C, {16'h0, pg[i]});
      rd_chk(8'h7C, {16'h0, pg[i]}, AXI_OKAY);
      rd_chk(8'h08, 32'h0, pg[i] == PAGE_GPIO ? AXI_SLVERR : AXI_OKAY);
      rd_chk(8'h48, 32'h0, pg[i] == PAGE_EXT1 ? AXI_OKAY : AXI_SLVERR);
    end
    hm_u.wr(8'h7C, 32'h0);
    rd_chk(8'h48, 32'h0, AXI_OKAY);
    hm_u.wr(8'h78, 32'h0401);
    link_up <= 1'b1;
    repeat (4) @(posedge mclk);
    chk_d({31'h0, indicator[0]}, 32'h1);
    link_up <= 1'b0;
    repeat (4) @(posedge mclk);
    chk_d({31'h0, indicator[0]}, 32'h0);
    // indicator one stretched: collision shows when combined, not when split
    hm_u.wr(8'h78, 32'h0C40);
    collision <= 1'b1;
    @(posedge mclk);
    collision <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_d({31'h0, indicator[1]}, 32'h1);
    hm_u.wr(8'h78, 32'h0C42);
    repeat (5100) @(posedge mclk);
    collision <= 1'b1;
    @(posedge mclk);
    collision <= 1'b0;
    repeat (3) @(posedge mclk);
    chk_d({31'h0, indicator[1]}, 32'h0);
    full_duplex <= 1'b1;
    repeat (3) @(posedge mclk);
    chk_d({31'h0, indicator[1]}, 32'h1);
    full_duplex <= 1'b0;
    ind_steady_23 <= 2'b01;
    // let the steady level reach the registered output before counting edges
    repeat (3) @(posedge mclk);
    toggles(t);
    chk_d(32'(t), 32'h0);
    hm_u.wr(8'h78, 32'h1401);
    toggles(t);
    chk_d({31'h0, t > 0}, 32'h1);
    ind_steady_23 <= 2'b00;
    // packet event through the interrupt path, enabled then masked
    hm_u.wr(8'h7C, 32'h1);
    hm_u.wr(8'h84, 32'h1);
    pkts(1);
    repeat (2) @(posedge mclk);
    chk_d({31'h0, irq}, 32'h1);
    rd_chk(8'h80, 32'h1, AXI_OKAY);
    @(posedge mclk);
    chk_d({31'h0, irq}, 32'h0);
    hm_u.wr(8'h84, 32'h0);
    pkts(1);
    repeat (2) @(posedge mclk);
    chk_d({31'h0, irq}, 32'h0);
    rd_chk(8'h48, exp_crc(2), AXI_OKAY);
    n = 1 + int'($urandom() % 40);
    pkts(n);
    rd_chk(8'h48, exp_crc(n), AXI_OKAY);
    rd_chk(8'h48, exp_crc(0), AXI_OKAY);
    pkts(10002);
    rd_chk(8'h48, exp_crc(10002), AXI_OKAY);
    report_and_stop();
  end
endmodule
